// File: rtl/tcx_regs.svh
// Purpose: constants for the trap, compare and exclusive-OR decode block
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   definitions only
`ifndef TCX_REGS_SVH
`define TCX_REGS_SVH

// ----------------------------------------
// primary opcodes
// ----------------------------------------
`define TCX_OP_SPECIAL  6'h00
`define TCX_OP_REG_IMMEDIATE_CLASS   6'h01
`define TCX_OP_EXCLUSIVE_OR_IMM     6'h0E
`define TCX_OP_SYSTEM_CONTROL_COPROC     6'h10
`define TCX_OP_FLOAT_COPROC     6'h11
`define TCX_OP_LL       6'h30
`define TCX_OP_LWC2     6'h32
`define TCX_OP_LLD      6'h34
`define TCX_OP_SC       6'h38
`define TCX_OP_SWC2     6'h3A
`define TCX_OP_SCD      6'h3C

// ----------------------------------------
// special function codes
// ----------------------------------------
`define TCX_FN_XOR      6'h26
`define TCX_FN_TRAP_LESS_REG_UNSIGNED     6'h33
`define TCX_FN_TNE      6'h36
`define TCX_FN_DMUL_LO  6'h1C
`define TCX_FN_DMUL_HI  6'h1F

// ----------------------------------------
// register-immediate rt codes
// ----------------------------------------
`define TCX_RI_TRAP_LESS_IMM     5'h0A
`define TCX_RI_TRAP_LESS_IMM_UNSIGNED    5'h0B
`define TCX_RI_TRAP_NOT_EQUAL_IMM     5'h0E
`define TCX_RI_GRP_BR   2'h0
`define TCX_RI_GRP_TRAP 2'h1
`define TCX_RI_GRP_BRAL 2'h2
`define TCX_RI_GRP_SA   2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define TCX_RST_DATA    64'h0000_0000_0000_0000

`endif

// File: rtl/tcx_pkg.sv
// Purpose: types shared by the decode block
// Assumes: nothing
// Notes:   state of the top module is one struct
`default_nettype none
package tcx_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [1:0] {
		TCX_CAUSE_NONE  = 2'b00,
		TCX_CAUSE_TRAP  = 2'b01,
		TCX_CAUSE_RSVD  = 2'b10,
		TCX_CAUSE_COPUN = 2'b11
	} tcx_cause_e;

	typedef struct packed {
		logic        done;
		logic        other;
		logic        wr_en;
		logic [4:0]  wr_addr;
		logic [63:0] wr_data;
		logic        exc;
		tcx_cause_e  cause;
		logic [1:0]  cop;
		logic        kill;
	} tcx_state_s;
endpackage
`default_nettype wire

// File: rtl/tcx_cmp.sv
// Purpose: 64-bit compare unit for the trap conditions
// Assumes: operands already forwarded
// Notes:   purely combinational
`default_nettype none
module tcx_cmp #(
	parameter int W = 64
) (
	input  wire logic [W-1:0] a,     // rs operand
	input  wire logic [W-1:0] b,     // rt or extended immediate
	output logic              lt_s,  // signed a < b
	output logic              lt_u,  // unsigned a < b
	output logic              ne     // a != b
);
	timeunit 1ns;
	timeprecision 1ps;
	// unsigned compare on full width only, nothing else feeds it
	assign lt_u = (a < b);
	assign lt_s = ($signed(a) < $signed(b));
	assign ne   = (a != b);
endmodule // tcx_cmp
`default_nettype wire

// File: rtl/tcx_decode.sv
// Purpose: decode and execute of trap, xor and register-immediate class
// Assumes: operands from register file, own last result and one forwarding source
// Notes:   all outputs registered, one cycle after the instruction
`include "tcx_regs.svh"
`default_nettype none
module tcx_decode #(
	parameter int W = 64
) (
	input  wire logic         clk_sys,    // core clock
	input  wire logic         rst_n,      // sync reset, active low
	input  wire logic         clk_en,     // freezes all state when low unless rst_n is low
	input  wire logic         in_valid,   // instruction present
	input  wire logic [31:0]  instr,      // instruction word
	input  wire logic [W-1:0] rs_file,    // rs from register file
	input  wire logic [W-1:0] rt_file,    // rt from register file
	input  wire logic         fwd_en,     // older result in flight
	input  wire logic [4:0]   fwd_addr,   // its destination
	input  wire logic [W-1:0] fwd_data,   // its value
	input  wire logic         cp0_usable, // system_control_coproc allowed
	input  wire logic         cp1_usable, // float_coproc allowed
	output logic              done,       // instruction handled here
	output logic              other,      // valid but for another unit
	output logic              wr_en,      // general_register write
	output logic [4:0]        wr_addr,    // destination
	output logic [W-1:0]      wr_data,    // result
	output logic              exc,        // exception raised
	output var tcx_pkg::tcx_cause_e cause, // exception cause
	output logic [1:0]        cop,        // coprocessor for unusable
	output logic              kill        // flush younger instructions
);
	timeunit 1ns;
	timeprecision 1ps;
	import tcx_pkg::*;

	// ----------------------------------------
	// fields
	// ----------------------------------------
	tcx_state_s st;
	tcx_state_s next_st;
	logic [5:0] op;
	logic [5:0] fn;
	logic [4:0] rs;
	logic [4:0] rt;
	logic [4:0] rd;
	logic [4:0] sa;
	logic [W-1:0] simm;
	logic [W-1:0] zimm;
	logic [W-1:0] a;
	logic [W-1:0] b_reg;
	logic [W-1:0] b_cmp;
	logic lt_s;
	logic lt_u;
	logic ne;
	logic is_ri;

	assign op   = instr[31:26];
	assign rs   = instr[25:21];
	assign rt   = instr[20:16];
	assign rd   = instr[15:11];
	assign sa   = instr[10:6];
	assign fn   = instr[5:0];
	assign simm = {{(W-16){instr[15]}}, instr[15:0]};
	assign zimm = {{(W-16){1'b0}}, instr[15:0]};
	assign is_ri = (op == `TCX_OP_REG_IMMEDIATE_CLASS);

	// ----------------------------------------
	// forwarding
	// ----------------------------------------
	// own last result is youngest, so it beats the outside source
	function automatic logic [W-1:0] fwd(input logic [4:0] ra, input logic [W-1:0] fv);
		logic [W-1:0] v;
		v = fv;
		if (ra == 5'h00)
			v = '0;
		else if (st.wr_en && st.wr_addr == ra)
			v = st.wr_data;
		else if (fwd_en && fwd_addr == ra)
			v = fwd_data;
		return v;
	endfunction

	assign a     = fwd(rs, rs_file);
	assign b_reg = fwd(rt, rt_file);
	// all three immediate trap forms compare against the sign-extended value
	assign b_cmp = is_ri ? simm : b_reg;

	tcx_cmp #(
		.W(W)
	) u_cmp (
		.a   (a),
		.b   (b_cmp),
		.lt_s(lt_s),
		.lt_u(lt_u),
		.ne  (ne)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	always_comb begin
		logic trap;
		trap = 1'b0;
		next_st = st;
		next_st.done  = 1'b0;
		next_st.other = 1'b0;
		next_st.wr_en = 1'b0;
		next_st.exc   = 1'b0;
		next_st.cause = TCX_CAUSE_NONE;
		next_st.cop   = 2'h0;
		next_st.kill  = 1'b0;
		if (in_valid) begin
			next_st.done = 1'b1;
			unique case (op)
				`TCX_OP_SPECIAL: begin
					// code field bits 15..6 never looked at for traps
					if (fn == `TCX_FN_TRAP_LESS_REG_UNSIGNED) begin
						trap = lt_u;
					end else if (fn == `TCX_FN_TNE) begin
						trap = ne;
					end else if (fn == `TCX_FN_XOR && sa == 5'h00) begin
						next_st.wr_en   = (rd != 5'h00);
						next_st.wr_addr = rd;
						next_st.wr_data = a ^ b_reg;
					end else if (fn >= `TCX_FN_DMUL_LO && fn <= `TCX_FN_DMUL_HI) begin
						next_st.exc   = 1'b1;
						next_st.cause = TCX_CAUSE_RSVD;
					end else if (fn == `TCX_FN_XOR) begin
						next_st.exc   = 1'b1;
						next_st.cause = TCX_CAUSE_RSVD;
					end else begin
						next_st.done  = 1'b0;
						next_st.other = 1'b1;
					end
				end
				`TCX_OP_REG_IMMEDIATE_CLASS: begin
					unique case (rt[4:3])
						`TCX_RI_GRP_BR, `TCX_RI_GRP_BRAL: begin
							if (rt[2] == 1'b0) begin
								next_st.done  = 1'b0;
								next_st.other = 1'b1;
							end else begin
								next_st.exc   = 1'b1;
								next_st.cause = TCX_CAUSE_RSVD;
							end
						end
						`TCX_RI_GRP_TRAP: begin
							if (rt == `TCX_RI_TRAP_LESS_IMM) begin
								trap = lt_s;
							end else if (rt == `TCX_RI_TRAP_LESS_IMM_UNSIGNED) begin
								trap = lt_u;
							end else if (rt == `TCX_RI_TRAP_NOT_EQUAL_IMM) begin
								trap = ne;
							end else if (rt[2:0] == 3'h5 || rt[2:0] == 3'h7) begin
								next_st.exc   = 1'b1;
								next_st.cause = TCX_CAUSE_RSVD;
							end else begin
								next_st.done  = 1'b0;
								next_st.other = 1'b1;
							end
						end
						`TCX_RI_GRP_SA: begin
							if (rt[2:1] == 2'h0) begin
								next_st.done  = 1'b0;
								next_st.other = 1'b1;
							end else begin
								next_st.exc   = 1'b1;
								next_st.cause = TCX_CAUSE_RSVD;
							end
						end
					endcase
				end
				`TCX_OP_EXCLUSIVE_OR_IMM: begin
					next_st.wr_en   = (rt != 5'h00);
					next_st.wr_addr = rt;
					next_st.wr_data = a ^ zimm;
				end
				`TCX_OP_LL, `TCX_OP_LLD, `TCX_OP_SC, `TCX_OP_SCD, `TCX_OP_LWC2, `TCX_OP_SWC2: begin
					next_st.exc   = 1'b1;
					next_st.cause = TCX_CAUSE_RSVD;
				end
				`TCX_OP_SYSTEM_CONTROL_COPROC, `TCX_OP_FLOAT_COPROC: begin
					// usable coprocessor work belongs to another unit
					if ((op == `TCX_OP_SYSTEM_CONTROL_COPROC) ? cp0_usable : cp1_usable) begin
						next_st.done  = 1'b0;
						next_st.other = 1'b1;
					end else begin
						next_st.exc   = 1'b1;
						next_st.cause = TCX_CAUSE_COPUN;
						next_st.cop   = {1'b0, op[0]};
					end
				end
				default: begin
					next_st.done  = 1'b0;
					next_st.other = 1'b1;
				end
			endcase
			if (trap) begin
				next_st.exc   = 1'b1;
				next_st.cause = TCX_CAUSE_TRAP;
			end
			next_st.kill = next_st.exc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '{done: 1'b0, other: 1'b0, wr_en: 1'b0, wr_addr: 5'h00,
			        wr_data: `TCX_RST_DATA, exc: 1'b0, cause: TCX_CAUSE_NONE,
			        cop: 2'h0, kill: 1'b0};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign done    = st.done;
	assign other   = st.other;
	assign wr_en   = st.wr_en;
	assign wr_addr = st.wr_addr;
	assign wr_data = st.wr_data;
	assign exc     = st.exc;
	assign cause   = st.cause;
	assign cop     = st.cop;
	assign kill    = st.kill;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic go;
	assign go = clk_en && in_valid;

	trap_less_imm_trap_a: assert property (go && is_ri && rt == `TCX_RI_TRAP_LESS_IMM
		|=> exc == ($signed($past(a)) < $signed($past(simm))))
		else $error("signed immediate trap wrong");
	trap_less_imm_unsigned_trap_a: assert property (go && is_ri && rt == `TCX_RI_TRAP_LESS_IMM_UNSIGNED
		|=> exc == ($past(a) < $past(simm)))
		else $error("unsigned immediate trap wrong");
	trap_less_reg_unsigned_trap_a: assert property (go && op == `TCX_OP_SPECIAL && fn == `TCX_FN_TRAP_LESS_REG_UNSIGNED
		|=> exc == ($past(a) < $past(b_reg)) && !wr_en)
		else $error("unsigned register trap wrong");
	tne_trap_a: assert property (go && op == `TCX_OP_SPECIAL && fn == `TCX_FN_TNE
		|=> exc == ($past(a) != $past(b_reg)))
		else $error("not-equal trap wrong");
	trap_not_equal_imm_trap_a: assert property (go && is_ri && rt == `TCX_RI_TRAP_NOT_EQUAL_IMM
		|=> exc == ($past(a) != $past(simm)))
		else $error("not-equal immediate trap wrong");
	xor_result_a: assert property (go && op == `TCX_OP_SPECIAL && fn == `TCX_FN_XOR && sa == 5'h00
		&& rd != 5'h00 |=> wr_en && !exc && wr_data == ($past(a) ^ $past(b_reg)))
		else $error("xor result wrong");
	exclusive_or_imm_result_a: assert property (go && op == `TCX_OP_EXCLUSIVE_OR_IMM && rt != 5'h00
		|=> wr_en && wr_addr == $past(rt) && wr_data == ($past(a) ^ $past(zimm)))
		else $error("xor immediate result wrong");
	zero_dest_a: assert property (wr_en |-> wr_addr != 5'h00)
		else $error("write to register zero");
	trap_kill_a: assert property (cause == TCX_CAUSE_TRAP |-> exc && kill && !wr_en)
		else $error("trap without kill or with write");
	cop_denied_a: assert property (go && op == `TCX_OP_SYSTEM_CONTROL_COPROC && !cp0_usable
		|=> exc && cause == TCX_CAUSE_COPUN && cop == 2'h0)
		else $error("coprocessor 0 unusable missed");
endmodule // tcx_decode
`default_nettype wire

// File: tb/tcx_pipe_model.sv
// Purpose: register file standing beside the decode block
// Assumes: bench preloads registers through the ld_* port
// Notes:   preload wins over a result write in the same cycle
`default_nettype none
module tcx_pipe_model (
	input  wire logic        clk_sys, // core clock
	input  wire logic        ld_en,   // preload strobe
	input  wire logic [4:0]  ld_addr, // preload register
	input  wire logic [63:0] ld_data, // preload value
	input  wire logic [31:0] instr,   // word being issued
	input  wire logic        wr_en,   // result write
	input  wire logic [4:0]  wr_addr, // result register
	input  wire logic [63:0] wr_data, // result value
	output logic      [63:0] rs_file, // rs read
	output logic      [63:0] rt_file  // rt read
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] gr [32];
	initial foreach (gr[i]) gr[i] = 64'h0;
	always @(posedge clk_sys) begin
		if (ld_en)
			gr[ld_addr] <= ld_data;
		else if (wr_en)
			gr[wr_addr] <= wr_data;
	end
	// register zero reads zero whatever was written
	assign rs_file = (instr[25:21] == 5'h0) ? 64'h0 : gr[instr[25:21]];
	assign rt_file = (instr[20:16] == 5'h0) ? 64'h0 : gr[instr[20:16]];
endmodule // tcx_pipe_model
`default_nettype wire

// File: tb/tb_trap_compare_xor_decode.sv
// Purpose: self-checking bench for the decode block
// Assumes: rs in register 1, rt in register 2, rd is register 3
// Notes:   rows first, then forwarding, stall and reset cases
`default_nettype none
module tb_trap_compare_xor_decode import tcx_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] ins;
		logic [63:0] a;
		logic [63:0] b;
		logic [1:0]  cs;  // expected cause
		logic        oth; // expected other
		logic        wr;  // expected write
		logic [63:0] wd;
	} tcx_row_s;
	logic clk_sys, rst_n, clk_en, in_valid, fwd_en, cp0_usable, cp1_usable, ld_en;
	logic [31:0] instr;
	logic [4:0]  fwd_addr, ld_addr, wr_addr;
	logic [63:0] fwd_data, ld_data, rs_file, rt_file, wr_data;
	logic        done, other, wr_en, exc, kill;
	logic [1:0]  cop;
	tcx_cause_e  cause;
	int          fail_count, tests_run, cycles;
	logic [5:0]  rop [6] = '{6'h30, 6'h32, 6'h34, 6'h38, 6'h3A, 6'h3C};
	tcx_row_s    rows [29] = '{
		'{32'h042A_FFFF, 64'hFFFF_FFFF_FFFF_FFFE, 64'h0, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h042A_FFFF, 64'h0, 64'h0, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h042B_8000, 64'hFFFF_FFFF_FFFF_7FFF, 64'h0, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h042B_8000, 64'hFFFF_FFFF_FFFF_8000, 64'h0, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h042B_7FFF, 64'h7FFE, 64'h0, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h0022_FFF3, 64'h1, 64'hFFFF_FFFF_FFFF_FFFF, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h0022_FFF3, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h0022_FFF3, 64'h5, 64'h5, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h0022_5576, 64'h8000_0000_0000_0000, 64'h0, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h0022_5576, 64'hA5, 64'hA5, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h042E_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h042E_FFFF, 64'hFFFF, 64'h0, 2'h1, 1'b0, 1'b0, 64'h0},
		'{32'h0022_1826, 64'hF0F0_0000_0000_1234, 64'h0FF0_0000_0000_4321, 2'h0, 1'b0, 1'b1,
			64'hFF00_0000_0000_5115},
		'{32'h3822_8001, 64'hFFFF_0000_0000_0001, 64'h0, 2'h0, 1'b0, 1'b1, 64'hFFFF_0000_0000_8000},
		'{32'h0022_0026, 64'h3, 64'h5, 2'h0, 1'b0, 1'b0, 64'h0},
		'{32'h0022_1866, 64'h3, 64'h5, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h042D_0000, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h0424_0000, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h043A_0000, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h0420_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0},
		'{32'h0428_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0},
		'{32'h0022_001C, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h0022_001F, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h4000_0000, 64'h0, 64'h0, 2'h3, 1'b0, 1'b0, 64'h0},
		'{32'h4400_0000, 64'h0, 64'h0, 2'h3, 1'b0, 1'b0, 64'h0},
		'{32'h0418_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0},
		'{32'h0430_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0},
		'{32'h0434_0000, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0},
		'{32'h3820_0001, 64'h5, 64'h0, 2'h0, 1'b0, 1'b0, 64'h0}};

	tcx_decode tcx_decode_i (.clk_sys, .rst_n, .clk_en, .in_valid, .instr, .rs_file, .rt_file, .fwd_en,
		.fwd_addr, .fwd_data, .cp0_usable, .cp1_usable, .done, .other, .wr_en, .wr_addr, .wr_data, .exc,
		.cause, .cop, .kill);
	tcx_pipe_model tcx_pipe_model_i (.clk_sys, .ld_en, .ld_addr, .ld_data, .instr, .wr_en, .wr_addr,
		.wr_data, .rs_file, .rt_file);

	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1000) begin
			fail_count++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic load(input logic [4:0] a, input logic [63:0] d);
		ld_en = 1'b1;
		ld_addr = a;
		ld_data = d;
		step;
	endtask
	task automatic run(input tcx_row_s r);
		load(5'd1, r.a);
		load(5'd2, r.b);
		ld_en = 1'b0;
		instr = r.ins;
		in_valid = 1'b1;
		step;
		in_valid = 1'b0;
		chk(done, !r.oth);
		chk(other, r.oth);
		chk(exc, r.cs != 2'h0);
		chk(cause, r.cs);
		chk(kill, r.cs != 2'h0);
		chk(wr_en & (wr_addr != 5'h0), r.wr);
		if (r.wr) begin
			chk(wr_addr, (r.ins[31:26] == 6'h00) ? r.ins[15:11] : r.ins[20:16]);
			chk(wr_data, r.wd);
		end
		if (r.cs == 2'h3)
			chk(cop, r.ins[27:26]);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		in_valid = 1'b0;
		instr = 32'h0;
		fwd_en = 1'b0;
		fwd_addr = 5'h0;
		fwd_data = 64'h0;
		cp0_usable = 1'b0;
		cp1_usable = 1'b0;
		ld_en = 1'b0;
		ld_addr = 5'h0;
		ld_data = 64'h0;
		repeat (20) step;
		chk(done, 1'b0);
		chk(exc, 1'b0);
		rst_n = 1'b1;
		foreach (rows[i]) run(rows[i]);
		foreach (rop[i]) run('{{rop[i], 26'h0}, 64'h0, 64'h0, 2'h2, 1'b0, 1'b0, 64'h0});
		cp0_usable = 1'b1;
		cp1_usable = 1'b1;
		run('{32'h4000_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0});
		run('{32'h4400_0000, 64'h0, 64'h0, 2'h0, 1'b1, 1'b0, 64'h0});
		// second word reads the first word's result before the file holds it
		load(5'd1, 64'h0);
		ld_en = 1'b0;
		// bus claims register zero, then register one; both claims must lose
		fwd_en = 1'b1;
		fwd_addr = 5'd0;
		fwd_data = 64'hFFFF_FFFF_FFFF_FFFF;
		instr = 32'h3801_1234;
		in_valid = 1'b1;
		step;
		chk(wr_data, 64'h0000_0000_0000_1234);
		fwd_addr = 5'd1;
		instr = 32'h042E_1234;
		step;
		in_valid = 1'b0;
		fwd_en = 1'b0;
		chk(exc, 1'b0);
		chk(done, 1'b1);
		step;
		chk(done, 1'b0);
		load(5'd4, 64'h0);
		ld_en = 1'b0;
		fwd_en = 1'b1;
		fwd_addr = 5'd4;
		fwd_data = 64'h5678;
		instr = 32'h048E_5678;
		in_valid = 1'b1;
		step;
		in_valid = 1'b0;
		fwd_en = 1'b0;
		chk(exc, 1'b0);
		// stalled cycles must not consume the waiting word
		run(rows[8]);
		clk_en = 1'b0;
		instr = 32'h0022_1826;
		step;
		in_valid = 1'b1;
		step;
		chk(exc, 1'b1);
		chk(wr_en, 1'b0);
		clk_en = 1'b1;
		step;
		in_valid = 1'b0;
		chk(exc, 1'b0);
		chk(wr_en, 1'b1);
		chk(wr_data, 64'h8000_0000_0000_0000);
		run(rows[0]);
		rst_n = 1'b0;
		step;
		chk(exc, 1'b0);
		chk(kill, 1'b0);
		chk(done, 1'b0);
		rst_n = 1'b1;
		run(rows[12]);
		wrap_up;
	end
endmodule // tb_trap_compare_xor_decode
`default_nettype wire
